// *** rtl/ddrcm_pkg.sv ***
// package: constants and carriers of the command and mode-register logic
// assumes one 200 MHz clock domain; command pins arrive from outside it
package ddrcm_pkg;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 2;
  localparam int DATA_W = 8;
  // mode register fields, then the auto-precharge address bit
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int OPM_LSB = 7;
  localparam int DLLRST_BIT = 8;
  localparam int AP_BIT = 10;
  // extended mode register fields
  localparam int DLL_DIS_BIT = 0;
  localparam int DRV_BIT = 1;
  localparam logic [2:0] BL2 = 3'h1;
  localparam logic [2:0] BL4 = 3'h2;
  localparam logic [2:0] BL8 = 3'h3;
  localparam logic [2:0] CL2 = 3'h2;
  localparam logic [2:0] CL25 = 3'h6;
  localparam logic [BANK_W-1:0] BANK_BASE = 2'h0;
  localparam logic [BANK_W-1:0] BANK_EXT = 2'h1;
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0062;
  localparam logic [ADDR_W-1:0] EXT_RST = 14'h0000;
  localparam int DLL_LOCK_CYC = 200;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddrcm_cmd_type;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_BST, OP_PRE, OP_PREALL,
    OP_AREF, OP_SREF, OP_MRS, OP_EMRS, OP_RSVD
  } ddrcm_op_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] col;
  } ddrcm_wr_type;
endpackage

// *** rtl/ddrcm_buf.sv ***
// two-entry valid/ready buffer on the write path
// assumes both sides on clk_sys
`timescale 1ns/1ps
`default_nettype none
module ddrcm_buf #(
  parameter int WIDTH = 24
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [2];
  logic [1:0] count, next_count;
  logic rd, next_rd, wr, next_wr;
  logic push, pop;

  assign in_ready = count != 2'h2;
  assign out_valid = count != 2'h0;
  assign out_data = mem[rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_count = count + {1'b0, push} - {1'b0, pop};
    next_wr = push ? ~wr : wr;
    next_rd = pop ? ~rd : rd;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count <= 2'h0;
      rd <= 1'b0;
      wr <= 1'b0;
    end else begin
      count <= next_count;
      rd <= next_rd;
      wr <= next_wr;
    end
    if (push) begin
      mem[wr] <= in_data;
    end
  end

  overflow_a: assert property (@(posedge clk_sys) disable iff (srst)
    count <= 2'h2) else $error("buffer count out of range");
endmodule
`default_nettype wire

// *** rtl/ddrcm_core.sv ***
// command decode, mode registers, read latency and masked write path
// assumes command pins come from the external controller, async to clk_sys
`timescale 1ns/1ps
`default_nettype none
module ddrcm_core
  import ddrcm_pkg::*;
#(
  parameter int LOCK_CYC = DLL_LOCK_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire ddrcm_cmd_type cmd_pin,
  input wire logic [DATA_W-1:0] wdata_pin,
  input wire logic dm_pin,
  output logic [ADDR_W-1:0] mode_reg,
  output logic [ADDR_W-1:0] ext_reg,
  output logic dll_on,
  output logic dll_ready,
  output logic self_refresh,
  output logic [3:0] bank_open,
  output logic burst_active,
  output logic burst_write,
  output logic auto_pre,
  output logic [2:0] burst_left,
  output logic rd_first,
  output logic refresh_pulse,
  output logic [ADDR_W-1:0] refresh_row,
  output logic illegal_cmd,
  output logic wr_valid,
  input wire logic wr_ready,
  output ddrcm_wr_type wr_word
);
  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  localparam int PW = $bits(ddrcm_cmd_type) + DATA_W + 1;
  logic [PW-1:0] sync1, sync2;
  ddrcm_cmd_type cmd;
  logic [DATA_W-1:0] wdata;
  logic dm;
  always_ff @(posedge clk_sys) begin
    sync1 <= {cmd_pin, wdata_pin, dm_pin};
    sync2 <= sync1;
  end
  assign {cmd, wdata, dm} = sync2;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  ddrcm_op_type op;
  always_comb begin
    op = OP_NOP;
    if (!cmd.cs_n) begin
      unique case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
        3'h7: op = OP_NOP;
        3'h3: op = OP_ACT;
        3'h5: op = OP_READ;
        3'h4: op = OP_WRITE;
        3'h6: op = OP_BST;
        3'h2: op = cmd.addr[AP_BIT] ? OP_PREALL : OP_PRE;
        3'h1: op = cmd.cke ? OP_AREF : OP_SREF;
        3'h0: begin
          if (cmd.bank == BANK_BASE) begin
            op = OP_MRS;
          end else if (cmd.bank == BANK_EXT) begin
            op = OP_EMRS;
          end else begin
            op = OP_RSVD;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode registers and dll
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] next_mode_reg, next_ext_reg;
  logic next_self_refresh, next_dll_ready, next_illegal_cmd;
  logic [8:0] lock_cnt, next_lock_cnt;
  logic dll_en;
  assign dll_en = !ext_reg[DLL_DIS_BIT] || self_refresh;

  always_comb begin
    next_mode_reg = mode_reg;
    next_ext_reg = ext_reg;
    next_self_refresh = self_refresh;
    next_lock_cnt = lock_cnt;
    next_illegal_cmd = 1'b0;
    if (self_refresh) begin
      if (cmd.cke) begin
        next_self_refresh = 1'b0;
        next_ext_reg[DLL_DIS_BIT] = 1'b0;
        next_lock_cnt = 9'h0;
      end
    end else begin
      // count first so that a load below can restart the lock time
      if (dll_en && cmd.cke && lock_cnt < 9'(LOCK_CYC)) begin
        next_lock_cnt = lock_cnt + 9'h1;
      end
      unique case (op)
        OP_MRS: begin
          next_mode_reg = cmd.addr;
          next_mode_reg[DLLRST_BIT] = 1'b0;
          if (cmd.addr[DLLRST_BIT]) begin
            next_lock_cnt = 9'h0;
          end
          if (cmd.addr[OPM_LSB] || cmd.addr[ADDR_W-1:DLLRST_BIT+1] != '0) begin
            next_illegal_cmd = 1'b1;
          end
        end
        OP_EMRS: begin
          next_ext_reg = cmd.addr;
          if (!cmd.addr[DLL_DIS_BIT]) begin
            next_lock_cnt = 9'h0;
          end
        end
        OP_SREF: next_self_refresh = 1'b1;
        OP_RSVD: next_illegal_cmd = 1'b1;
        default: ;
      endcase
      if (op == OP_READ && !dll_ready) begin
        next_illegal_cmd = 1'b1;
      end
    end
    next_dll_ready = dll_en && next_lock_cnt >= 9'(LOCK_CYC);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_reg <= MODE_RST;
      ext_reg <= EXT_RST;
      self_refresh <= 1'b0;
      lock_cnt <= 9'h0;
      dll_ready <= 1'b0;
      dll_on <= 1'b0;
      illegal_cmd <= 1'b0;
    end else begin
      mode_reg <= next_mode_reg;
      ext_reg <= next_ext_reg;
      self_refresh <= next_self_refresh;
      lock_cnt <= next_lock_cnt;
      dll_ready <= next_dll_ready;
      dll_on <= !next_ext_reg[DLL_DIS_BIT];
      illegal_cmd <= next_illegal_cmd;
    end
  end

  // ----------------------------------------------------------------
  // banks, bursts and refresh
  // ----------------------------------------------------------------
  logic [3:0] next_bank_open;
  logic next_burst_active, next_burst_write, next_auto_pre;
  logic [2:0] next_burst_left, len;
  logic next_refresh_pulse;
  logic [ADDR_W-1:0] next_refresh_row;
  logic [BANK_W-1:0] burst_bank, next_burst_bank;
  logic [ADDR_W-1:0] col, next_col;
  logic [2:0] wrap_mask;

  always_comb begin
    unique case (mode_reg[BL_LSB +: 3])
      BL2: len = 3'h1;
      BL4: len = 3'h3;
      BL8: len = 3'h7;
      default: len = 3'h1;
    endcase
    wrap_mask = len;
  end

  always_comb begin
    next_bank_open = bank_open;
    next_burst_active = burst_active;
    next_burst_write = burst_write;
    next_auto_pre = auto_pre;
    next_burst_left = burst_left;
    next_burst_bank = burst_bank;
    next_col = col;
    next_refresh_pulse = 1'b0;
    next_refresh_row = refresh_row;
    if (burst_active) begin
      next_col[2:0] = (col[2:0] & ~wrap_mask) | ((col[2:0] + 3'h1) & wrap_mask);
      if (burst_left == 3'h0) begin
        next_burst_active = 1'b0;
        if (auto_pre) begin
          next_bank_open[burst_bank] = 1'b0;
        end
      end else begin
        next_burst_left = burst_left - 3'h1;
      end
    end
    if (!self_refresh) begin
      unique case (op)
        OP_ACT: next_bank_open[cmd.bank] = 1'b1;
        OP_READ, OP_WRITE: begin
          next_burst_active = 1'b1;
          next_burst_write = op == OP_WRITE;
          next_auto_pre = cmd.addr[AP_BIT];
          next_burst_left = len;
          next_burst_bank = cmd.bank;
          next_col = cmd.addr;
        end
        OP_BST: begin
          if (burst_active && !burst_write && !auto_pre) begin
            next_burst_active = 1'b0;
          end
        end
        OP_PRE: next_bank_open[cmd.bank] = 1'b0;
        OP_PREALL: next_bank_open = 4'h0;
        OP_AREF, OP_SREF: begin
          next_refresh_pulse = 1'b1;
          next_refresh_row = refresh_row + 14'h1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bank_open <= 4'h0;
      burst_active <= 1'b0;
      burst_write <= 1'b0;
      auto_pre <= 1'b0;
      burst_left <= 3'h0;
      burst_bank <= 2'h0;
      col <= 14'h0;
      refresh_pulse <= 1'b0;
      refresh_row <= 14'h0;
    end else begin
      bank_open <= next_bank_open;
      burst_active <= next_burst_active;
      burst_write <= next_burst_write;
      auto_pre <= next_auto_pre;
      burst_left <= next_burst_left;
      burst_bank <= next_burst_bank;
      col <= next_col;
      refresh_pulse <= next_refresh_pulse;
      refresh_row <= next_refresh_row;
    end
  end

  // ----------------------------------------------------------------
  // read latency: whole clocks, 2.5 rounds up to 3
  // ----------------------------------------------------------------
  logic [3:0] rd_pipe, next_rd_pipe;
  logic rd_hit;
  assign rd_hit = (op == OP_READ) && !self_refresh;
  always_comb begin
    next_rd_pipe = {rd_pipe[2:0], rd_hit};
    next_rd_pipe[0] = rd_hit;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_pipe <= 4'h0;
      rd_first <= 1'b0;
    end else begin
      rd_pipe <= next_rd_pipe;
      rd_first <= (mode_reg[CL_LSB +: 3] == CL2) ? rd_pipe[0] : rd_pipe[1];
    end
  end

  // ----------------------------------------------------------------
  // masked write path
  // ----------------------------------------------------------------
  ddrcm_wr_type wr_in;
  logic wr_push, in_ready;
  ddrcm_wr_type buf_out;
  logic buf_valid;
  assign wr_in = '{data: wdata, bank: burst_bank, col: col};
  assign wr_push = burst_active && burst_write && !dm;

  ddrcm_buf #(.WIDTH($bits(ddrcm_wr_type))) u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(wr_push),
    .in_ready(in_ready),
    .in_data(wr_in),
    .out_valid(buf_valid),
    .out_ready(wr_ready || !wr_valid),
    .out_data(buf_out)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_valid <= 1'b0;
      wr_word <= '0;
    end else if (wr_ready || !wr_valid) begin
      wr_valid <= buf_valid;
      wr_word <= buf_out;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rd_latency_a: assert property (@(posedge clk_sys) disable iff (srst)
    rd_hit && mode_reg[CL_LSB +: 3] == CL2 && $stable(mode_reg)
    |-> ##2 rd_first) else $error("read data late");
  dll_reset_a: assert property (@(posedge clk_sys) disable iff (srst)
    !self_refresh && op == OP_MRS |=> !mode_reg[DLLRST_BIT])
    else $error("dll reset bit stuck");
  mrs_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    !self_refresh && op == OP_MRS
    |=> mode_reg[6:0] == $past(cmd.addr[6:0]))
    else $error("mode load lost");
  ext_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    !self_refresh && op == OP_EMRS |=> ext_reg == $past(cmd.addr))
    else $error("extended load lost");
  sref_exit_a: assert property (@(posedge clk_sys) disable iff (srst)
    self_refresh && cmd.cke |=> !self_refresh && dll_on)
    else $error("dll off after self refresh");
  act_open_a: assert property (@(posedge clk_sys) disable iff (srst)
    !self_refresh && op == OP_ACT |=> bank_open[$past(cmd.bank)])
    else $error("bank not opened");
  preall_a: assert property (@(posedge clk_sys) disable iff (srst)
    !self_refresh && op == OP_PREALL |=> bank_open == 4'h0)
    else $error("precharge all missed");
  refresh_a: assert property (@(posedge clk_sys) disable iff (srst)
    !self_refresh && op == OP_AREF
    |=> refresh_pulse && refresh_row == $past(refresh_row) + 14'h1)
    else $error("refresh not counted");
  nop_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    op == OP_NOP && !burst_active |=> $stable(bank_open))
    else $error("idle cycle changed banks");
  mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    dm |-> !wr_push) else $error("masked data written");
endmodule
`default_nettype wire

// *** testbench/ddrcm_host.sv ***
// partner model: memory controller driving command, data and mask pins
// assumes the bench calls its tasks; pins change at clk_sys rising edge
`timescale 1ns/1ps
`default_nettype none
module ddrcm_host
  import ddrcm_pkg::*;
(
  input wire logic clk_sys,
  output ddrcm_cmd_type cmd_pin,
  output logic [DATA_W-1:0] wdata_pin,
  output logic dm_pin
);
  initial begin
    cmd_pin = {5'h1f, 2'h0, 14'h0000};
    wdata_pin = 8'h00;
    dm_pin = 1'b1;
  end

  // ----------------------------------------
  // one command, then deselect with bank and address driven inverted
  // ----------------------------------------
  // strobes s = {cs_n, ras_n, cas_n, we_n}; cke kept as given
  task automatic send(input logic [3:0] s, input logic k,
                      input logic [1:0] b, input logic [13:0] a);
    @(posedge clk_sys);
    cmd_pin <= {s, k, b, a};
    @(posedge clk_sys);
    cmd_pin.cs_n <= 1'b1;
    cmd_pin.addr <= ~a;
    cmd_pin.bank <= ~b;
  endtask

  // data and mask held until changed
  task automatic drive(input logic [7:0] d, input logic m);
    @(posedge clk_sys);
    wdata_pin <= d;
    dm_pin <= m;
  endtask
endmodule
`default_nettype wire

// *** testbench/ddrcm_core_test.sv ***
// self-checking bench of the command and mode-register logic
// assumes ddrcm_host stands in for the memory controller
`timescale 1ns/1ps
`default_nettype none
module ddrcm_core_test;
  import ddrcm_pkg::*;
  localparam int LOCK = 8;
  logic clk_sys, srst, wr_ready, stall;
  ddrcm_cmd_type cmd_pin;
  logic [7:0] wdata_pin;
  logic dm_pin, dll_on, dll_ready, self_refresh, burst_active, burst_write;
  logic auto_pre, rd_first, refresh_pulse, illegal_cmd, wr_valid;
  logic [13:0] mode_reg, ext_reg, refresh_row, r0;
  logic [3:0] bank_open;
  logic [2:0] burst_left;
  ddrcm_wr_type wr_word, e;
  ddrcm_wr_type exp_wr[$];
  int exp_rd[$];
  int cyc = 0, n_ill = 0, n_ref = 0, n_mismatch = 0, samples_checked = 0;
  int i0;

  ddrcm_host host (.clk_sys(clk_sys), .cmd_pin(cmd_pin),
    .wdata_pin(wdata_pin), .dm_pin(dm_pin));
  ddrcm_core #(.LOCK_CYC(LOCK)) uut (.clk_sys(clk_sys), .srst(srst),
    .cmd_pin(cmd_pin), .wdata_pin(wdata_pin), .dm_pin(dm_pin),
    .mode_reg(mode_reg), .ext_reg(ext_reg), .dll_on(dll_on),
    .dll_ready(dll_ready), .self_refresh(self_refresh),
    .bank_open(bank_open), .burst_active(burst_active),
    .burst_write(burst_write), .auto_pre(auto_pre),
    .burst_left(burst_left), .rd_first(rd_first),
    .refresh_pulse(refresh_pulse), .refresh_row(refresh_row),
    .illegal_cmd(illegal_cmd), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic cmd(input logic [3:0] s, input logic k,
                     input logic [1:0] b, input logic [13:0] a);
    host.send(s, k, b, a);
    settle(4);
  endtask

  // read; lat < 0 means no first-data pulse is noted
  task automatic rd(input logic [13:0] a, input int lat);
    @(posedge clk_sys);
    if (lat > 0) exp_rd.push_back(cyc + 1 + lat);
    host.send(4'h5, 1'b1, 2'h0, a);
  endtask

  task automatic wr(input logic [13:0] col, input int bl, input logic m);
    logic [7:0] d;
    logic [13:0] c;
    d = 8'($urandom);
    host.drive(d, m);
    for (int j = 0; j < bl; j++) begin
      c = (col & ~14'(bl - 1)) | ((col + 14'(j)) & 14'(bl - 1));
      if (!m) exp_wr.push_back('{data: d, bank: 2'h1, col: c});
    end
    host.send(4'h4, 1'b1, 2'h1, col);
    settle(3);
    check(burst_write === 1'b1 && burst_left === 3'(bl - 1), "wr burst");
    settle(9);
    host.drive(~d, 1'b1);
  endtask

  // ----------------------------------------
  // monitor: oldest note against each result
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (illegal_cmd === 1'b1) n_ill++;
    if (refresh_pulse === 1'b1) n_ref++;
    if (rd_first === 1'b1 && exp_rd.size() > 0)
      check(cyc == exp_rd.pop_front(), "first read data time");
    if (!srst && wr_valid === 1'b1 && wr_ready) begin
      if (exp_wr.size() == 0) check(1'b0, "unexpected write word");
      else begin
        e = exp_wr.pop_front();
        check(wr_word === e, "write word");
      end
    end
    wr_ready <= stall ? 1'($urandom) : 1'b1;
  end

  initial begin
    settle(20000);
    check(1'b0, "timeout");
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    stall = 1'b0;
    wr_ready = 1'b1;
    void'($urandom(32'h435509ec));
    settle(6);
    srst <= 1'b0;
    @(posedge clk_sys);
    check(mode_reg === MODE_RST && ext_reg === EXT_RST, "reset");
    cmd(4'h0, 1'b1, BANK_EXT, 14'h0000);
    check(ext_reg === 14'h0000 && dll_on === 1'b1, "ext load");
    cmd(4'h0, 1'b1, BANK_BASE, 14'h0122);
    check(mode_reg === 14'h0022 && dll_ready === 1'b0, "dll reset");
    i0 = n_ill;
    rd(14'h0000, -1);
    settle(4);
    check(n_ill == i0 + 1, "early read");
    cmd(4'h0, 1'b1, BANK_BASE, 14'h0022);
    check(mode_reg === 14'h0022, "normal load");
    i0 = n_ill;
    cmd(4'h0, 1'b1, 2'h2, 14'h0031);
    check(n_ill == i0 + 1 && mode_reg === 14'h0022, "bank code");
    cmd(4'h0, 1'b1, BANK_BASE, 14'h00a2);
    check(n_ill == i0 + 2 && mode_reg === 14'h00a2, "op bits");
    cmd(4'h0, 1'b1, BANK_BASE, 14'h0062);
    settle(LOCK + 4);
    check(dll_ready === 1'b1, "dll lock count");
    cmd(4'h3, 1'b1, 2'h1, 14'h0010);
    check(bank_open === 4'h2, "activate");
    cmd(4'h3, 1'b1, 2'h3, 14'h0011);
    cmd(4'h2, 1'b1, 2'h1, 14'h0000);
    check(bank_open === 4'h8, "precharge one");
    cmd(4'h3, 1'b1, 2'h0, 14'h0012);
    cmd(4'h2, 1'b1, 2'h0, 14'h0400);
    check(bank_open === 4'h0, "precharge all");
    cmd(4'h3, 1'b1, 2'h0, 14'h0012);
    rd(14'h0004, 6);
    settle(8);
    cmd(4'h0, 1'b1, BANK_BASE, 14'h0022);
    rd(14'h0004, 5);
    settle(8);
    cmd(4'h0, 1'b1, BANK_BASE, 14'h0063);
    rd(14'h0000, -1);
    host.send(4'h6, 1'b1, 2'h0, 14'h0000);
    settle(3);
    check(burst_active === 1'b0, "burst stop");
    settle(8);
    rd(14'h0400, -1);
    settle(3);
    check(auto_pre === 1'b1, "auto precharge");
    host.send(4'h6, 1'b1, 2'h0, 14'h0000);
    settle(3);
    check(burst_active === 1'b1, "stop refused");
    settle(8);
    rd(14'h0000, -1);
    host.send(4'h7, 1'b1, 2'h0, 14'h0000);
    settle(3);
    check(burst_active === 1'b1, "nop in burst");
    settle(8);
    cmd(4'h0, 1'b1, BANK_BASE, 14'h0022);
    wr(14'h0006, 4, 1'b0);
    cmd(4'h0, 1'b1, BANK_BASE, 14'h0021);
    wr(14'h0005, 2, 1'b1);
    stall = 1'b1;
    wr(14'h0005, 2, 1'b0);
    stall = 1'b0;
    r0 = refresh_row;
    i0 = n_ref;
    cmd(4'h1, 1'b1, 2'h0, 14'h0000);
    check(n_ref == i0 + 1 && refresh_row === r0 + 14'h0001, "ref");
    cmd(4'h0, 1'b1, BANK_EXT, 14'h0001);
    check(dll_on === 1'b0, "dll off");
    cmd(4'h1, 1'b0, 2'h0, 14'h0000);
    check(self_refresh === 1'b1, "self refresh");
    cmd(4'h7, 1'b1, 2'h0, 14'h0000);
    check(self_refresh === 1'b0 && dll_on === 1'b1, "sr exit");
    for (int k = 0; k < 50 && exp_wr.size() + exp_rd.size() > 0; k++)
      settle(1);
    check(exp_wr.size() == 0 && exp_rd.size() == 0, "notes left");
    report_and_stop();
  end
endmodule
`default_nettype wire
